/* design/oad_decoder.sv */
// operand address decoder: prefix, addressing byte, displacement, immediate and offset bytes
// Contract
// - split addressing byte into mode 7:6, middle 5:3, register-or-memory 2:0
// - mode 11 means register operand and no displacement bytes
// - mode 00 means no displacement and zero displacement, except direct address
// - mode 01 reads one sign-extended byte; mode 10 reads two bytes low first
// - mode 11 middle codes select byte or word registers in standard order
// - extended opcodes use the middle field as operation extension 0 to 7
// - register-form opcodes use middle field as register, width from opcode
// - codes 000..011 address BX+SI, BX+DI, BP+SI and BX+DI plus displacement
// - code 110 with mode 00 uses a 16-bit displacement as the address
// - displacement adds to the offset, never to the segment
// - immediate data is one or two bytes after addressing and displacement
// - prefix byte pattern 001xx110 carries segment selector in bits 4:3
// - selector 00 ES, 01 CS, 10 SS, 11 DS
// - prefix precedes the opcode and applies to the next memory operand; code spends it on the next instruction, even in register form
// - code offsets are a byte, a word, or offset then segment words
// - opcode decides whether immediates are signed or unsigned
// - signed immediates are two's complement, byte or word range
// - embedded word register comes from opcode low three bits
// - string operands use DS:SI as source and ES:DI as destination
`timescale 1ns/1ns
module oad_decoder (
	// clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic pready_o,
	output logic [31:0] prdata_o,
	output logic pslverr_o,
	// byte stream from fetch queue, attributes valid with the opcode byte
	input wire logic [7:0] byte_i,
	input wire logic byte_valid_i,
	output logic byte_ready_o,
	input wire logic op_modrm_i,
	input wire logic op_ext_i,
	input wire logic op_word_i,
	input wire logic op_imm_i,
	input wire logic op_imm_word_i,
	input wire logic op_imm_signed_i,
	input wire logic [1:0] op_off_kind_i,
	input wire logic op_emb_reg_i,
	input wire logic op_string_i,
	// register file values used for address formation
	input wire logic [15:0] bx_i,
	input wire logic [15:0] bp_i,
	input wire logic [15:0] si_i,
	input wire logic [15:0] di_i,
	// decoded instruction, valid for the one cycle of done_o
	output logic done_o,
	output logic [7:0] opcode_o,
	output logic is_reg_o,
	output logic [2:0] rm_sel_o,
	output logic [2:0] reg_sel_o,
	output logic reg_word_o,
	output logic [2:0] op_ext_o,
	output logic [2:0] emb_reg_o,
	output logic [15:0] effective_address_o,
	output logic [1:0] segment_selector_o,
	output logic seg_override_o,
	output logic [15:0] disp_o,
	output logic [15:0] immediate_o,
	output logic [31:0] code_offset_o,
	output logic [15:0] string_src_ea_o,
	output logic [15:0] string_dst_ea_o
);
	import oad_pkg::*;

	typedef struct packed {
		oad_state_t st;
		logic ready;
		logic en;
		logic [15:0] count;
		logic [7:0] opcode;
		logic a_modrm;
		logic a_ext;
		logic a_word;
		logic a_imm;
		logic a_immw;
		logic a_imms;
		logic [1:0] a_off;
		logic a_emb;
		logic a_str;
		logic [7:0] modrm;
		logic ovr_valid;
		logic [1:0] ovr_sel;
		logic [15:0] disp;
		logic [1:0] dcnt;
		logic [15:0] imm;
		logic [1:0] icnt;
		logic [31:0] off;
		logic [2:0] ocnt;
		logic done;
		logic is_reg;
		logic [2:0] rm_sel;
		logic [2:0] reg_sel;
		logic reg_word;
		logic [2:0] op_ext;
		logic [2:0] emb_reg;
		logic [15:0] ea;
		logic [1:0] seg;
		logic seg_ovr;
		logic [15:0] disp_out;
		logic [15:0] imm_out;
		logic [31:0] off_out;
		logic [15:0] str_src;
		logic [15:0] str_dst;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} oad_regs_t;

	oad_regs_t s_q;
	oad_regs_t s_d;

	// ****************************************
	// helpers
	// ****************************************
	// picks the phase after the addressing and displacement bytes
	function automatic oad_state_t oad_next_phase(input logic imm, input logic [1:0] off);
		if (imm) begin
			return OAD_S_IMM;
		end else if (off != OAD_OFF_NONE) begin
			return OAD_S_OFF;
		end
		return OAD_S_DONE;
	endfunction : oad_next_phase

	// base and index sum for a memory operand
	function automatic logic [15:0] oad_base(input logic [2:0] rm, input logic [15:0] bx,
			input logic [15:0] bp, input logic [15:0] si, input logic [15:0] di);
		logic [15:0] r;
		r = 16'h0000;
		case (rm)
			3'b000: r = bx + si;
			3'b001: r = bx + di;
			3'b010: r = bp + si;
			3'b011: r = bx + di;
			3'b100: r = si;
			3'b101: r = di;
			3'b110: r = bp;
			3'b111: r = bx;
			default: r = 16'h0000;
		endcase
		return r;
	endfunction : oad_base

	function automatic logic [2:0] oad_off_bytes(input logic [1:0] kind);
		case (kind)
			OAD_OFF_BYTE: return 3'd1;
			OAD_OFF_WORD: return 3'd2;
			OAD_OFF_FAR: return 3'd4;
			default: return 3'd0;
		endcase
	endfunction : oad_off_bytes

	logic accept;
	logic is_prefix;
	logic apb_access;
	logic [1:0] mod_f;
	logic [2:0] rm_f;
	logic [15:0] disp_eff;
	logic direct;

	assign accept = byte_valid_i & s_q.ready;
	assign is_prefix = (byte_i & OAD_PFX_MASK) == OAD_PFX_MATCH;
	assign apb_access = psel_i & penable_i;
	assign mod_f = s_q.modrm[OAD_MOD_HI:OAD_MOD_LO];
	assign rm_f = s_q.modrm[OAD_RM_HI:OAD_RM_LO];
	assign direct = (mod_f == OAD_MOD_NODISP) && (rm_f == OAD_RM_DIRECT);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		disp_eff = 16'h0000;
		if (mod_f == OAD_MOD_DISP8) begin
			disp_eff = {{8{s_q.disp[15]}}, s_q.disp[15:8]};
		end else if (mod_f == OAD_MOD_DISP16 || direct) begin
			disp_eff = s_q.disp;
		end
		case (s_q.st)
			OAD_S_OPC: begin
				if (accept && is_prefix) begin
					// only taken ahead of the opcode; a later match is data
					s_d.ovr_valid = 1'b1;
					s_d.ovr_sel = byte_i[OAD_PFX_SEL_HI:OAD_PFX_SEL_LO];
				end else if (accept) begin
					s_d.opcode = byte_i;
					s_d.a_modrm = op_modrm_i;
					s_d.a_ext = op_ext_i;
					s_d.a_word = op_word_i;
					s_d.a_imm = op_imm_i;
					s_d.a_immw = op_imm_word_i;
					s_d.a_imms = op_imm_signed_i;
					s_d.a_off = op_off_kind_i;
					s_d.a_emb = op_emb_reg_i;
					s_d.a_str = op_string_i;
					s_d.modrm = {OAD_MOD_REG, 6'b00_0000};
					s_d.disp = 16'h0000;
					s_d.imm = 16'h0000;
					s_d.off = 32'h0000_0000;
					s_d.icnt = op_imm_word_i ? 2'd2 : 2'd1;
					s_d.ocnt = oad_off_bytes(op_off_kind_i);
					s_d.st = op_modrm_i ? OAD_S_MODRM : oad_next_phase(op_imm_i, op_off_kind_i);
				end
			end
			OAD_S_MODRM: begin
				if (accept) begin
					s_d.modrm = byte_i;
					s_d.dcnt = 2'd0;
					if (byte_i[OAD_MOD_HI:OAD_MOD_LO] == OAD_MOD_DISP8) begin
						s_d.dcnt = OAD_DISP8_BYTES;
					end else if (byte_i[OAD_MOD_HI:OAD_MOD_LO] == OAD_MOD_DISP16) begin
						s_d.dcnt = OAD_DISP16_BYTES;
					end else if (byte_i[OAD_MOD_HI:OAD_MOD_LO] == OAD_MOD_NODISP &&
							byte_i[OAD_RM_HI:OAD_RM_LO] == OAD_RM_DIRECT) begin
						s_d.dcnt = OAD_DISP16_BYTES;
					end
					if (s_d.dcnt != 2'd0) begin
						s_d.st = OAD_S_DISP;
					end else begin
						s_d.st = oad_next_phase(s_q.a_imm, s_q.a_off);
					end
				end
			end
			OAD_S_DISP: begin
				if (accept) begin
					// bytes enter at the top so the low byte arrives first
					s_d.disp = {byte_i, s_q.disp[15:8]};
					s_d.dcnt = s_q.dcnt - 2'd1;
					if (s_q.dcnt == 2'd1) begin
						s_d.st = oad_next_phase(s_q.a_imm, s_q.a_off);
					end
				end
			end
			OAD_S_IMM: begin
				if (accept) begin
					s_d.imm = {byte_i, s_q.imm[15:8]};
					s_d.icnt = s_q.icnt - 2'd1;
					if (s_q.icnt == 2'd1) begin
						s_d.st = oad_next_phase(1'b0, s_q.a_off);
					end
				end
			end
			OAD_S_OFF: begin
				if (accept) begin
					s_d.off = {byte_i, s_q.off[31:8]};
					s_d.ocnt = s_q.ocnt - 3'd1;
					if (s_q.ocnt == 3'd1) begin
						s_d.st = OAD_S_DONE;
					end
				end
			end
			OAD_S_DONE: begin
				s_d.done = 1'b1;
				s_d.st = OAD_S_OPC;
				s_d.count = s_q.count + 16'h0001;
				s_d.is_reg = (mod_f == OAD_MOD_REG);
				s_d.rm_sel = rm_f;
				s_d.reg_sel = s_q.a_ext ? 3'b000 : s_q.modrm[OAD_MID_HI:OAD_MID_LO];
				s_d.reg_word = s_q.a_word;
				s_d.op_ext = s_q.a_ext ? s_q.modrm[OAD_MID_HI:OAD_MID_LO] : 3'b000;
				s_d.emb_reg = s_q.a_emb ? s_q.opcode[2:0] : 3'b000;
				s_d.disp_out = disp_eff;
				// the displacement only ever touches the offset part
				if (direct) begin
					s_d.ea = s_q.disp;
				end else if (mod_f == OAD_MOD_REG || !s_q.a_modrm) begin
					s_d.ea = 16'h0000;
				end else begin
					s_d.ea = oad_base(rm_f, bx_i, bp_i, si_i, di_i) + disp_eff;
				end
				// string operands fix their own segments; an override hits the modrm operand
				s_d.seg = s_q.ovr_valid ? s_q.ovr_sel : OAD_SEG_DS;
				s_d.seg_ovr = s_q.ovr_valid;
				s_d.ovr_valid = 1'b0;
				s_d.str_src = s_q.a_str ? si_i : 16'h0000;
				s_d.str_dst = s_q.a_str ? di_i : 16'h0000;
				if (!s_q.a_imm) begin
					s_d.imm_out = 16'h0000;
				end else if (s_q.a_immw) begin
					s_d.imm_out = s_q.imm;
				end else if (s_q.a_imms) begin
					s_d.imm_out = {{8{s_q.imm[15]}}, s_q.imm[15:8]};
				end else begin
					s_d.imm_out = {8'h00, s_q.imm[15:8]};
				end
				case (s_q.a_off)
					OAD_OFF_BYTE: s_d.off_out = {24'h00_0000, s_q.off[31:24]};
					OAD_OFF_WORD: s_d.off_out = {16'h0000, s_q.off[31:16]};
					OAD_OFF_FAR: s_d.off_out = s_q.off;
					default: s_d.off_out = 32'h0000_0000;
				endcase
			end
			default: s_d.st = OAD_S_OPC;
		endcase

		// apb: one wait state, answer in the second access cycle
		s_d.pready = apb_access & ~s_q.pready;
		if (apb_access && !s_q.pready) begin
			s_d.pslverr = 1'b0;
			case (paddr_i)
				OAD_ADDR_CTRL: s_d.prdata = {31'h0000_0000, s_q.en};
				OAD_ADDR_STATUS: s_d.prdata = {s_q.count, 14'h0000, s_q.ovr_valid,
						s_q.st != OAD_S_OPC};
				OAD_ADDR_LAST_EA: s_d.prdata = {13'h0000, s_q.seg_ovr, s_q.seg, s_q.ea};
				OAD_ADDR_LAST_DATA: s_d.prdata = {s_q.disp_out, s_q.imm_out};
				OAD_ADDR_LAST_OFF: s_d.prdata = s_q.off_out;
				default: begin
					s_d.prdata = OAD_RDATA_RST;
					s_d.pslverr = 1'b1;
				end
			endcase
		end else begin
			s_d.prdata = OAD_RDATA_RST;
			s_d.pslverr = 1'b0;
		end
		if (apb_access && s_q.pready && pwrite_i && paddr_i == OAD_ADDR_CTRL) begin
			s_d.en = pwdata_i[OAD_CTRL_EN_BIT];
			if (pwdata_i[OAD_CTRL_CLR_BIT]) begin
				s_d.count = OAD_COUNT_RST;
			end
		end
		// disabling stalls the fetch side between bytes; decoding resumes on enable
		s_d.ready = s_d.en && (s_d.st != OAD_S_DONE);
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			s_q <= '0;
			s_q.st <= OAD_S_OPC;
			s_q.en <= OAD_CTRL_EN_RST;
			s_q.count <= OAD_COUNT_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign pready_o = s_q.pready;
	assign prdata_o = s_q.prdata;
	assign pslverr_o = s_q.pslverr;
	assign byte_ready_o = s_q.ready;
	assign done_o = s_q.done;
	assign opcode_o = s_q.opcode;
	assign is_reg_o = s_q.is_reg;
	assign rm_sel_o = s_q.rm_sel;
	assign reg_sel_o = s_q.reg_sel;
	assign reg_word_o = s_q.reg_word;
	assign op_ext_o = s_q.op_ext;
	assign emb_reg_o = s_q.emb_reg;
	assign effective_address_o = s_q.ea;
	assign segment_selector_o = s_q.seg;
	assign seg_override_o = s_q.seg_ovr;
	assign disp_o = s_q.disp_out;
	assign immediate_o = s_q.imm_out;
	assign code_offset_o = s_q.off_out;
	assign string_src_ea_o = s_q.str_src;
	assign string_dst_ea_o = s_q.str_dst;

	// ****************************************
	// assertions
	// ****************************************
	property p_reg_mode;
		@(posedge clock_i) disable iff (!resetn_i)
		done_o |-> (is_reg_o == (s_q.modrm[7:6] == 2'b11));
	endproperty
	a_reg_mode: assert property (p_reg_mode) else $error("register mode flag wrong");

	property p_no_disp_reg;
		@(posedge clock_i) disable iff (!resetn_i)
		(s_q.st == OAD_S_MODRM && accept && byte_i[7:6] == 2'b11) |=> (s_q.st != OAD_S_DISP);
	endproperty
	a_no_disp_reg: assert property (p_no_disp_reg) else $error("disp fetched in reg mode");

	property p_disp8;
		@(posedge clock_i) disable iff (!resetn_i)
		(s_q.st == OAD_S_MODRM && accept && byte_i[7:6] == 2'b01)
			|=> (s_q.st == OAD_S_DISP && s_q.dcnt == 2'd1);
	endproperty
	a_disp8: assert property (p_disp8) else $error("mode 01 not one disp byte");

	property p_disp16;
		@(posedge clock_i) disable iff (!resetn_i)
		(s_q.st == OAD_S_MODRM && accept && (byte_i[7:6] == 2'b10 || byte_i[7:0] ==? 8'b00??_?110))
			|=> (s_q.st == OAD_S_DISP && s_q.dcnt == 2'd2);
	endproperty
	a_disp16: assert property (p_disp16) else $error("expected two disp bytes");

	property p_direct;
		@(posedge clock_i) disable iff (!resetn_i)
		(done_o && s_q.a_modrm && s_q.modrm[7:6] == 2'b00 && s_q.modrm[2:0] == 3'b110)
			|-> (effective_address_o == s_q.disp && disp_o == s_q.disp);
	endproperty
	a_direct: assert property (p_direct) else $error("direct address not used");

	property p_ext_field;
		@(posedge clock_i) disable iff (!resetn_i)
		done_o |-> (s_q.a_ext ? (op_ext_o == s_q.modrm[5:3] && reg_sel_o == 3'b000)
			: (reg_sel_o == s_q.modrm[5:3]));
	endproperty
	a_ext_field: assert property (p_ext_field) else $error("middle field misrouted");

	property p_prefix;
		@(posedge clock_i) disable iff (!resetn_i)
		(s_q.st == OAD_S_OPC && accept && byte_i[7:5] == 3'b001 && byte_i[2:0] == 3'b110)
			|=> (s_q.ovr_valid && s_q.ovr_sel == $past(byte_i[4:3]) && s_q.st == OAD_S_OPC);
	endproperty
	a_prefix: assert property (p_prefix) else $error("prefix not captured");

	property p_seg_apply;
		@(posedge clock_i) disable iff (!resetn_i)
		done_o |-> (segment_selector_o == ($past(s_q.ovr_valid) ? $past(s_q.ovr_sel) : 2'b11)
			&& !s_q.ovr_valid);
	endproperty
	a_seg_apply: assert property (p_seg_apply) else $error("override not applied once");

	property p_imm_sign;
		@(posedge clock_i) disable iff (!resetn_i)
		(done_o && s_q.a_imm && !s_q.a_immw)
			|-> (immediate_o[15:8] == (s_q.a_imms ? {8{immediate_o[7]}} : 8'h00));
	endproperty
	a_imm_sign: assert property (p_imm_sign) else $error("byte immediate extension wrong");

	property p_apb_wait;
		@(posedge clock_i) disable iff (!resetn_i)
		$rose(psel_i & penable_i) |-> !pready_o ##1 pready_o;
	endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("apb answer timing wrong");

endmodule : oad_decoder

/* design/oad_pkg.sv */
// constants, field layouts and state type for the operand address decoder
package oad_pkg;

	// ****************************************
	// apb register map
	// ****************************************
	localparam logic [7:0] OAD_ADDR_CTRL = 8'h00;
	localparam logic [7:0] OAD_ADDR_STATUS = 8'h04;
	localparam logic [7:0] OAD_ADDR_LAST_EA = 8'h08;
	localparam logic [7:0] OAD_ADDR_LAST_DATA = 8'h0C;
	localparam logic [7:0] OAD_ADDR_LAST_OFF = 8'h10;
	localparam int OAD_CTRL_EN_BIT = 0;
	localparam int OAD_CTRL_CLR_BIT = 1;
	localparam logic OAD_CTRL_EN_RST = 1'b1;
	localparam logic [31:0] OAD_RDATA_RST = 32'h0000_0000;
	localparam logic [15:0] OAD_COUNT_RST = 16'h0000;

	// ****************************************
	// addressing byte fields
	// ****************************************
	localparam int OAD_MOD_HI = 7;
	localparam int OAD_MOD_LO = 6;
	localparam int OAD_MID_HI = 5;
	localparam int OAD_MID_LO = 3;
	localparam int OAD_RM_HI = 2;
	localparam int OAD_RM_LO = 0;
	localparam logic [1:0] OAD_MOD_NODISP = 2'b00;
	localparam logic [1:0] OAD_MOD_DISP8 = 2'b01;
	localparam logic [1:0] OAD_MOD_DISP16 = 2'b10;
	localparam logic [1:0] OAD_MOD_REG = 2'b11;
	localparam logic [2:0] OAD_RM_DIRECT = 3'b110;
	localparam logic [1:0] OAD_DISP8_BYTES = 2'd1;
	localparam logic [1:0] OAD_DISP16_BYTES = 2'd2;

	// ****************************************
	// segment override prefix and selectors
	// ****************************************
	localparam logic [7:0] OAD_PFX_MASK = 8'hE7;
	localparam logic [7:0] OAD_PFX_MATCH = 8'h26;
	localparam int OAD_PFX_SEL_HI = 4;
	localparam int OAD_PFX_SEL_LO = 3;
	localparam logic [1:0] OAD_SEG_ES = 2'b00;
	localparam logic [1:0] OAD_SEG_CS = 2'b01;
	localparam logic [1:0] OAD_SEG_SS = 2'b10;
	localparam logic [1:0] OAD_SEG_DS = 2'b11;

	// ****************************************
	// code offset operand kinds
	// ****************************************
	localparam logic [1:0] OAD_OFF_NONE = 2'b00;
	localparam logic [1:0] OAD_OFF_BYTE = 2'b01;
	localparam logic [1:0] OAD_OFF_WORD = 2'b10;
	localparam logic [1:0] OAD_OFF_FAR = 2'b11;

	typedef enum logic [2:0] {
		OAD_S_OPC,
		OAD_S_MODRM,
		OAD_S_DISP,
		OAD_S_IMM,
		OAD_S_OFF,
		OAD_S_DONE
	} oad_state_t;

endpackage : oad_pkg

/* tb/oad_decoder_tb.sv */
// self-checking bench for the operand address decoder
`timescale 1ns/1ns
module oad_decoder_tb;
	import oad_pkg::*;
	// ****************************************
	// wiring
	// ****************************************
	logic clock_i = 1'b0, resetn_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic slow = 1'b0, er;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, rd, seed = 32'd82041;
	logic [15:0] bx = 16'h0000, bp = 16'h0000, si = 16'h0000, di = 16'h0000;
	logic pready, pslverr, byte_ready, byte_valid, done, is_reg, reg_word, ovr;
	logic [31:0] prdata, code_off;
	logic [7:0] byte_d, opcode;
	logic [9:0] attr;
	logic [2:0] rm_sel, reg_sel, op_ext, emb;
	logic [15:0] ea, disp, imm, src, dst;
	logic [1:0] seg;
	logic [136:0] exp_q[$];
	logic [136:0] last, e;
	int failures = 0, cmp_count = 0, n_sent = 0;

	oad_fetch_model fm (.clock_i(clock_i), .resetn_i(resetn_i), .slow_i(slow),
		.byte_ready_i(byte_ready), .byte_o(byte_d), .byte_valid_o(byte_valid), .attr_o(attr));

	oad_decoder dut (.clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
		.prdata_o(prdata), .pslverr_o(pslverr), .byte_i(byte_d), .byte_valid_i(byte_valid),
		.byte_ready_o(byte_ready), .op_modrm_i(attr[9]), .op_ext_i(attr[8]),
		.op_word_i(attr[7]), .op_imm_i(attr[6]), .op_imm_word_i(attr[5]),
		.op_imm_signed_i(attr[4]), .op_off_kind_i(attr[3:2]), .op_emb_reg_i(attr[1]),
		.op_string_i(attr[0]), .bx_i(bx), .bp_i(bp), .si_i(si), .di_i(di), .done_o(done),
		.opcode_o(opcode), .is_reg_o(is_reg), .rm_sel_o(rm_sel), .reg_sel_o(reg_sel),
		.reg_word_o(reg_word), .op_ext_o(op_ext), .emb_reg_o(emb), .effective_address_o(ea),
		.segment_selector_o(seg), .seg_override_o(ovr), .disp_o(disp), .immediate_o(imm),
		.code_offset_o(code_off), .string_src_ea_o(src), .string_dst_ea_o(dst));

	initial begin
		forever #20 clock_i = ~clock_i;
	end

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run

	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1'b1;
		do @(posedge clock_i); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock_i);
	endtask : apb

	function automatic logic [15:0] base(input logic [2:0] rm);
		case (rm)
			3'd0: return bx + si;
			3'd1, 3'd3: return bx + di;
			3'd2: return bp + si;
			3'd4: return si;
			3'd5: return di;
			3'd6: return bp;
			default: return bx;
		endcase
	endfunction : base

	// one random instruction; mode and r/m walk through all 32 pairs
	task automatic send();
		logic [31:0] r;
		logic [7:0] opc, mrm;
		logic [9:0] at;
		logic [1:0] sg, md;
		logic ov;
		logic [15:0] dp, ad, im;
		logic [31:0] off;
		int np, nd, ni, no;
		r = rnd();
		np = (r[1:0] == 2'b11) ? 0 : int'(r[1:0]);
		sg = 2'b11;
		ov = 1'b0;
		for (int i = 0; i < np; i++) begin
			r = rnd();
			sg = r[1:0];
			ov = 1'b1;
			fm.push({10'h000, 8'h26 | {3'b000, sg, 3'b000}});
		end
		r = rnd();
		opc = r[7:0];
		if ((opc & 8'hE7) == 8'h26) begin
			opc ^= 8'h01;
		end
		// later instructions sometimes carry no addressing byte: register form, no address
		at = {~(n_sent[5] & r[18]), r[17:9]};
		mrm = at[9] ? {n_sent[1:0], r[29:27], n_sent[4:2]} : 8'hC0;
		md = mrm[7:6];
		fm.push({at, opc});
		if (at[9]) begin
			fm.push({at, mrm});
		end
		r = rnd();
		nd = (md == 2'b01) ? 1 : (md == 2'b10 || (md == 2'b00 && mrm[2:0] == 3'b110)) ? 2 : 0;
		dp = (nd == 1) ? {{8{r[7]}}, r[7:0]} : (nd == 2) ? r[15:0] : 16'h0000;
		for (int i = 0; i < nd; i++) fm.push({at, r[8*i +: 8]});
		ad = (md == 2'b11) ? 16'h0000 : (nd == 2 && md == 2'b00) ? dp : base(mrm[2:0]) + dp;
		r = rnd();
		ni = at[6] ? (at[5] ? 2 : 1) : 0;
		im = (ni == 2) ? r[15:0] : (ni == 1) ? {{8{r[7] & at[4]}}, r[7:0]} : 16'h0000;
		for (int i = 0; i < ni; i++) fm.push({at, r[8*i +: 8]});
		r = rnd();
		no = (at[3:2] == 2'b11) ? 4 : int'(at[3:2]);
		off = (no == 4) ? r : r & ((32'h0000_0001 << (8 * no)) - 32'h0000_0001);
		for (int i = 0; i < no; i++) fm.push({at, r[8*i +: 8]});
		last = {ad, sg, ov, dp, im, off, opc, md == 2'b11, mrm[2:0], at[8] ? 3'b000 : mrm[5:3],
			at[7], at[8] ? mrm[5:3] : 3'b000, at[1] ? opc[2:0] : 3'b000,
			at[0] ? si : 16'h0000, at[0] ? di : 16'h0000};
		exp_q.push_back(last);
		n_sent++;
	endtask : send

	task automatic drain();
		for (int i = 0; i < 800 && exp_q.size() != 0; i++) @(posedge clock_i);
		check("drained", 64'h0, 64'(exp_q.size()));
	endtask : drain

	// ****************************************
	// result monitor
	// ****************************************
	always @(posedge clock_i) begin
		if (resetn_i && done === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("spurious done", 64'h0, 64'h1);
			end else begin
				e = exp_q.pop_front();
				check("ea seg disp", 64'(e[136:102]),
					64'({ea, seg, ovr, disp}));
				check("imm off", 64'(e[101:54]), 64'({imm, code_off}));
				check("fields", 64'(e[53:32]), 64'({opcode, is_reg, rm_sel, reg_sel, reg_word,
					op_ext, emb}));
				check("string", 64'(e[31:0]), 64'({src, dst}));
			end
		end
	end

	initial begin
		repeat (20000) @(posedge clock_i);
		failures++;
		complete_run();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge clock_i);
		resetn_i <= 1'b1;
		@(posedge clock_i);
		apb(1'b1, OAD_ADDR_STATUS, 32'hFFFF_FFFF);
		apb(1'b0, OAD_ADDR_CTRL, 32'h0000_0000);
		check("ctrl reset", 64'h1, 64'({er, rd}));
		apb(1'b0, OAD_ADDR_STATUS, 32'h0000_0000);
		check("status reset", 64'h0, 64'({er, rd}));
		apb(1'b0, 8'h14, 32'h0000_0000);
		check("unmapped", 64'h1_0000_0000, 64'({er, rd}));
		// batches back to back, odd batches with a stalling fetch queue
		for (int k = 0; k < 8; k++) begin
			slow <= k[0];
			{bx, bp, si, di} <= {rnd(), rnd()};
			@(posedge clock_i);
			for (int j = 0; j < 8; j++) send();
			drain();
		end
		apb(1'b0, OAD_ADDR_STATUS, 32'h0000_0000);
		check("count", 64'h0040_0000, 64'(rd));
		apb(1'b0, OAD_ADDR_LAST_EA, 32'h0000_0000);
		check("last ea", 64'({last[118], last[120:119], last[136:121]}), 64'(rd));
		apb(1'b0, OAD_ADDR_LAST_DATA, 32'h0000_0000);
		check("last data", 64'(last[117:86]), 64'(rd));
		apb(1'b0, OAD_ADDR_LAST_OFF, 32'h0000_0000);
		check("last off", 64'(last[85:54]), 64'(rd));
		apb(1'b1, OAD_ADDR_CTRL, 32'h0000_0002);
		send();
		repeat (12) @(posedge clock_i);
		check("held ready", 64'h0, 64'(byte_ready));
		check("held pending", 64'h1, 64'(exp_q.size()));
		apb(1'b1, OAD_ADDR_CTRL, 32'h0000_0001);
		drain();
		apb(1'b0, OAD_ADDR_STATUS, 32'h0000_0000);
		check("count after clear", 64'h0001_0000, 64'(rd));
		complete_run();
	end
endmodule : oad_decoder_tb

/* tb/oad_fetch_model.sv */
// fetch queue model: offers instruction bytes and opcode attributes to the decoder
`timescale 1ns/1ns
module oad_fetch_model (
	// clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// byte stream
	input wire logic slow_i,
	input wire logic byte_ready_i,
	output logic [7:0] byte_o,
	output logic byte_valid_o,
	output logic [9:0] attr_o
);
	logic [17:0] fifo_q[$];
	logic [31:0] lfsr_q = 32'h0000_1D2B;

	function automatic void push(input logic [17:0] ent);
		fifo_q.push_back(ent);
	endfunction : push

	initial begin
		byte_o = 8'h00;
		byte_valid_o = 1'b0;
		attr_o = 10'h000;
	end

	always @(posedge clock_i) begin
		lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
		if (!resetn_i) begin
			byte_valid_o <= 1'b0;
		end else if (!byte_valid_o || byte_ready_i) begin
			// an offered byte is held until taken, so field order stays intact
			if (byte_valid_o) begin
				void'(fifo_q.pop_front());
			end
			if (fifo_q.size() != 0 && !(slow_i && lfsr_q[0])) begin
				{attr_o, byte_o} <= fifo_q[0];
				byte_valid_o <= 1'b1;
			end else begin
				// an idle line must not keep showing the last byte
				byte_o <= ~byte_o;
				attr_o <= ~attr_o;
				byte_valid_o <= 1'b0;
			end
		end
	end
endmodule : oad_fetch_model
